// [src/mem_pins_map.vh]
// constants for the memory bus pin signalling block: timing, pin fields,
// reset values; included by every design file that needs them
`ifndef MEM_PINS_MAP_VH
`define MEM_PINS_MAP_VH

// internal clock period in ns
`define CLK_PERIOD_NS 40
// least times of each bus phase in ns
`define T_PRE_NS 80
`define T_ROW_NS 80
`define T_COL_NS 40
`define T_DATA_NS 80
// least times rounded up to whole clock cycles
`define CYC_PRE ((`T_PRE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CYC_ROW ((`T_ROW_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CYC_COL ((`T_COL_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CYC_DATA ((`T_DATA_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// shared address/data line fields
`define AD_FAULT_BIT 8
`define AD_ROW_LSB 9
`define AD_ROW_MSB 31

// reset values
`define BIT_OUT_RESET 8'h00
`define BIT_IN_RESET 8'hff

`endif

// [src/sel_sample.v]
// per-bit sampler: takes a value from its dedicated pin or, when the pin
// is not selected, from a shared address/data line in a qualifying state
// assumes all inputs are synchronous to clk_in
`timescale 1ns/10ps
`default_nettype none

module sel_sample #(
    parameter W = 8,
    parameter [W-1:0] RST_VAL = {W{1'b1}}
) (
    input wire clk_in,              // internal clock
    input wire rst_n_in,            // synchronous reset, active low
    input wire pin_sel_in,          // 1: dedicated pin, 0: shared line
    input wire [W-1:0] pin_val_in,  // dedicated pin values
    input wire [W-1:0] ad_val_in,   // shared line values
    input wire qual_in,             // strobe state lets shared line through
    output wire [W-1:0] held_out    // registered sample
);

    reg [W-1:0] held_reg;

    assign held_out = held_reg;

    // one flop per bit; shared-line value held between qualifying states
    genvar i;
    generate
        for (i = 0; i < W; i = i + 1) begin : g_bit
            always @(posedge clk_in) begin
                if (!rst_n_in) begin
                    held_reg[i] <= RST_VAL[i];
                end else if (pin_sel_in) begin
                    held_reg[i] <= pin_val_in[i];
                end else if (qual_in) begin
                    held_reg[i] <= ad_val_in[i];
                end
            end
        end
    endgenerate

endmodule

`default_nettype wire

// [src/mem_bus_pins.v]
// memory bus pin signalling: row/column strobes, data-on-bus, output
// enable, bit outputs and the bit/fault/reset inputs that may share the
// low address/data lines.
// assumes a bus sequencer issues one cycle request at a time and that
// the shared lines are resolved outside from AD_OUT and AD_OE_OUT.
//
// Function
// R1 - pin fault select set: asserted fault aborts main cycle and traps.
// R2 - pin fault select clear: fault read from line 8 at row fall.
// R3 - bit input select set: bit inputs taken from dedicated pins.
// R4 - bit input select clear: bits from low lines, row on, column off.
// R5 - bit outputs written by both processors, drive dedicated output pins.
// R6 - bit outputs also shown on low lines while row strobe inactive.
// R7 - row strobe held asserted until another row cycle is needed; a line fault abort also releases it.
// R8 - column strobe marks valid column address on the lines.
// R9 - data-on-bus active in data part, inactive in address part.
// R10 - output enable active exactly for reads from memory.
// R11 - outside hardware asserts fault before row strobe becomes active.
// R12 - column strobe released at end of the bus cycle.
// R13 - reset pin unused at power-up means reset comes from line 8.
// R14 - low lines left undriven while the outside drives sampled values.
// R15 - shared-line samples registered in qualifying state, held until next.
`timescale 1ns/10ps
`default_nettype none
`include "mem_pins_map.vh"

module mem_bus_pins (
    input wire REF_CLK_IN,          // internal clock, 25 MHz
    input wire RESET_N_IN,          // synchronous reset, active low
    input wire PWRUP_IN,            // power-up window, high
    input wire FAULT_PIN_SEL_IN,    // 1: fault on its own pin
    input wire BIT_PIN_SEL_IN,      // 1: bit inputs on their own pins
    input wire REQ_IN,              // start a bus cycle, pulse
    input wire REQ_READ_IN,         // cycle is a read from memory
    input wire REQ_MAIN_IN,         // cycle is for main_processor
    input wire NEW_ROW_IN,          // cycle needs a new row address
    input wire [22:0] ROW_ADDR_IN,  // row address
    input wire [22:0] COL_ADDR_IN,  // column address
    input wire [31:0] WDATA_IN,     // write data
    input wire FAULT_N_IN,          // memory fault pin, active low
    input wire [7:0] BIT_IN,        // dedicated bit input pins
    input wire MAIN_WR_IN,          // main_processor writes all bits
    input wire [7:0] MAIN_WDATA_IN, // main_processor bit values
    input wire IO_SET_IN,           // io_processor sets one bit
    input wire IO_CLR_IN,           // io_processor clears one bit
    input wire [2:0] IO_SEL_IN,     // io_processor bit index
    input wire [31:0] AD_IN,        // shared lines, sensed
    output reg [31:0] AD_OUT,       // shared lines, driven value
    output reg [31:0] AD_OE_OUT,    // shared lines, per-bit enable
    output reg RAS_N_OUT,           // row strobe, active low
    output reg CAS_N_OUT,           // column strobe, active low
    output reg DOB_N_OUT,           // data on bus, active low
    output reg OE_N_OUT,            // output enable, active low
    output reg [7:0] BIT_OUT,       // bit output pins
    output wire [7:0] BITS_SAMPLED_OUT, // bit inputs as sampled
    output reg RDATA_VALID_OUT,     // cycle finished, pulse
    output reg [31:0] RDATA_OUT,    // read data
    output reg TRAP_OUT,            // main_processor fault trap, pulse
    output reg CPU_RESET_OUT        // reset request to the core, high
);

    localparam S_IDLE = 3'h0;
    localparam S_PRE = 3'h1;
    localparam S_RAS = 3'h2;
    localparam S_COL = 3'h3;
    localparam S_DATA = 3'h4;

    // phase counts kept full width, then cut to the 4-bit counter on purpose
    localparam [31:0] PRE_W = `CYC_PRE - 1;
    localparam [31:0] ROW_W = `CYC_ROW - 1;
    localparam [31:0] COL_W = `CYC_COL - 1;
    localparam [31:0] DATA_W = `CYC_DATA - 1;
    localparam [3:0] LAST_PRE = PRE_W[3:0];
    localparam [3:0] LAST_ROW = ROW_W[3:0];
    localparam [3:0] LAST_COL = COL_W[3:0];
    localparam [3:0] LAST_DATA = DATA_W[3:0];

    reg [2:0] state_reg, state_next;
    reg [3:0] cnt_reg, cnt_next;
    reg open_reg, open_next;
    reg read_reg, main_reg;
    reg [22:0] row_reg, col_reg;
    reg [31:0] wdata_reg;
    reg ras_n_prev_reg;
    reg fault_ad_reg;
    reg use_pin_reg;
    reg ras_n_next, cas_n_next, dob_n_next, oe_n_next;
    reg done_next, trap_next;
    reg [31:0] rdata_next, ad_next, ad_oe_next;
    reg [7:0] bits_next;
    wire [22:0] cur_row, cur_col;
    wire [31:0] cur_wdata;
    wire cur_read;
    wire qual;
    wire reset_held;

    // request fields are live in idle, latched afterwards
    assign cur_row = (state_reg == S_IDLE) ? ROW_ADDR_IN : row_reg;
    assign cur_col = (state_reg == S_IDLE) ? COL_ADDR_IN : col_reg;
    assign cur_wdata = (state_reg == S_IDLE) ? WDATA_IN : wdata_reg;
    assign cur_read = (state_reg == S_IDLE) ? REQ_READ_IN : read_reg;

    // low lines carry outside values while row is on and column off
    assign qual = !RAS_N_OUT && CAS_N_OUT;

    // R3 bit input select
    // R4 shared line bits
    // R15 hold samples
    sel_sample #(.W(8), .RST_VAL(`BIT_IN_RESET)) u_bits (
        .clk_in(REF_CLK_IN),
        .rst_n_in(RESET_N_IN),
        .pin_sel_in(BIT_PIN_SEL_IN),
        .pin_val_in(BIT_IN),
        .ad_val_in(AD_IN[7:0]),
        .qual_in(qual),
        .held_out(BITS_SAMPLED_OUT)
    );

    // R13 reset from line
    sel_sample #(.W(1), .RST_VAL(1'b1)) u_rst (
        .clk_in(REF_CLK_IN),
        .rst_n_in(RESET_N_IN),
        .pin_sel_in(use_pin_reg),
        .pin_val_in(RESET_N_IN),
        .ad_val_in(AD_IN[`AD_FAULT_BIT]),
        .qual_in(qual),
        .held_out(reset_held)
    );

    // R13 power-up strap
    // a reset pin held low during power-up keeps the pin in use;
    // otherwise the pin is ignored and line 8 carries reset
    always @(posedge REF_CLK_IN) begin
        if (PWRUP_IN) begin
            use_pin_reg <= !RESET_N_IN;
        end
    end

    // R5 bit output writes
    // the io_processor bit op lands on top of a same-cycle group write
    always @* begin
        bits_next = BIT_OUT;
        if (MAIN_WR_IN) begin
            bits_next = MAIN_WDATA_IN;
        end
        if (IO_SET_IN) begin
            bits_next[IO_SEL_IN] = 1'b1;
        end else if (IO_CLR_IN) begin
            bits_next[IO_SEL_IN] = 1'b0;
        end
    end

    // cycle sequencer and next strobe levels
    always @* begin
        state_next = state_reg;
        cnt_next = cnt_reg + 4'h1;
        open_next = open_reg;
        ras_n_next = RAS_N_OUT;
        cas_n_next = 1'b1;
        dob_n_next = 1'b1;
        oe_n_next = 1'b1;
        done_next = 1'b0;
        trap_next = 1'b0;
        rdata_next = RDATA_OUT;
        case (state_reg)
            S_IDLE: begin
                cnt_next = 4'h0;
                if (REQ_IN) begin
                    if (FAULT_PIN_SEL_IN && REQ_MAIN_IN && !FAULT_N_IN) begin
                        // R1 pin fault abort
                        trap_next = 1'b1;
                        done_next = 1'b1;
                    end else if (open_reg && !NEW_ROW_IN) begin
                        // R8 same row, column
                        state_next = S_COL;
                        cas_n_next = 1'b0;
                    end else if (open_reg) begin
                        // R7 new row release
                        state_next = S_PRE;
                        ras_n_next = 1'b1;
                        open_next = 1'b0;
                    end else begin
                        state_next = S_RAS;
                        ras_n_next = 1'b0;
                        open_next = 1'b1;
                    end
                end
            end
            S_PRE: begin
                if (cnt_reg == LAST_PRE) begin
                    state_next = S_RAS;
                    cnt_next = 4'h0;
                    ras_n_next = 1'b0;
                    open_next = 1'b1;
                end
            end
            S_RAS: begin
                if (cnt_reg == LAST_ROW) begin
                    cnt_next = 4'h0;
                    if (!FAULT_PIN_SEL_IN && main_reg && fault_ad_reg) begin
                        // R1 line fault abort
                        // no column cycle inside a faulted row cycle
                        state_next = S_IDLE;
                        ras_n_next = 1'b1;
                        open_next = 1'b0;
                        trap_next = 1'b1;
                        done_next = 1'b1;
                    end else begin
                        state_next = S_COL;
                        cas_n_next = 1'b0;
                    end
                end
            end
            S_COL: begin
                cas_n_next = 1'b0;
                if (cnt_reg == LAST_COL) begin
                    // R9 data part begins
                    // R10 read enable
                    state_next = S_DATA;
                    cnt_next = 4'h0;
                    dob_n_next = 1'b0;
                    oe_n_next = !read_reg;
                end
            end
            S_DATA: begin
                cas_n_next = 1'b0;
                dob_n_next = 1'b0;
                oe_n_next = !read_reg;
                if (cnt_reg == LAST_DATA) begin
                    // R12 column release
                    // R7 row stays on
                    state_next = S_IDLE;
                    cas_n_next = 1'b1;
                    dob_n_next = 1'b1;
                    oe_n_next = 1'b1;
                    done_next = 1'b1;
                    if (read_reg) begin
                        rdata_next = AD_IN;
                    end
                end
            end
            default: begin
                state_next = S_IDLE;
                ras_n_next = 1'b1;
                open_next = 1'b0;
            end
        endcase
    end

    // shared line drive follows the strobe levels about to appear
    always @* begin
        ad_next = 32'h0000_0000;
        ad_oe_next = 32'h0000_0000;
        if (ras_n_next) begin
            // R6 bits on low lines
            ad_next[7:0] = bits_next;
            ad_oe_next[7:0] = 8'hff;
        end else if (cas_n_next) begin
            // R14 low lines released
            ad_next[`AD_ROW_MSB:`AD_ROW_LSB] = cur_row;
            ad_oe_next[`AD_ROW_MSB:`AD_ROW_LSB] = 23'h7f_ffff;
        end else if (dob_n_next) begin
            ad_next[`AD_ROW_MSB:`AD_ROW_LSB] = cur_col;
            ad_oe_next = 32'hffff_ffff;
        end else if (!cur_read) begin
            ad_next = cur_wdata;
            ad_oe_next = 32'hffff_ffff;
        end
    end

    // state, latched request and every output pin except CPU_RESET_OUT and BITS_SAMPLED_OUT
    always @(posedge REF_CLK_IN) begin
        if (!RESET_N_IN) begin
            state_reg <= S_IDLE;
            cnt_reg <= 4'h0;
            open_reg <= 1'b0;
            read_reg <= 1'b0;
            main_reg <= 1'b0;
            row_reg <= 23'h00_0000;
            col_reg <= 23'h00_0000;
            wdata_reg <= 32'h0000_0000;
            RAS_N_OUT <= 1'b1;
            CAS_N_OUT <= 1'b1;
            DOB_N_OUT <= 1'b1;
            OE_N_OUT <= 1'b1;
            AD_OUT <= 32'h0000_0000;
            AD_OE_OUT <= 32'h0000_0000;
            BIT_OUT <= `BIT_OUT_RESET;
            RDATA_VALID_OUT <= 1'b0;
            RDATA_OUT <= 32'h0000_0000;
            TRAP_OUT <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            open_reg <= open_next;
            if (state_reg == S_IDLE && REQ_IN) begin
                read_reg <= REQ_READ_IN;
                main_reg <= REQ_MAIN_IN;
                row_reg <= ROW_ADDR_IN;
                col_reg <= COL_ADDR_IN;
                wdata_reg <= WDATA_IN;
            end
            RAS_N_OUT <= ras_n_next;
            CAS_N_OUT <= cas_n_next;
            DOB_N_OUT <= dob_n_next;
            OE_N_OUT <= oe_n_next;
            AD_OUT <= ad_next;
            AD_OE_OUT <= ad_oe_next;
            BIT_OUT <= bits_next;
            RDATA_VALID_OUT <= done_next;
            RDATA_OUT <= rdata_next;
            TRAP_OUT <= trap_next;
        end
    end

    // R2 fault at row fall
    // sampled only on the first cycle of row active with column off
    always @(posedge REF_CLK_IN) begin
        if (!RESET_N_IN) begin
            ras_n_prev_reg <= 1'b1;
            fault_ad_reg <= 1'b0;
            CPU_RESET_OUT <= 1'b1;
        end else begin
            ras_n_prev_reg <= RAS_N_OUT;
            if (!RAS_N_OUT && ras_n_prev_reg && CAS_N_OUT) begin
                fault_ad_reg <= !AD_IN[`AD_FAULT_BIT];
            end
            CPU_RESET_OUT <= !reset_held;
        end
    end

endmodule

`default_nettype wire

// [sim/mem_pins_sva.sv]
// checker for the memory bus pin block: strobes, bit paths, sampling
// assumes it is bound to mem_bus_pins and sees only its ports
`timescale 1ns/10ps
`default_nettype none
module mem_pins_sva (
    input wire REF_CLK_IN, // clock
    input wire RESET_N_IN, // reset, low
    input wire BIT_PIN_SEL_IN, // bit pin select
    input wire MAIN_WR_IN, // group write
    input wire [7:0] MAIN_WDATA_IN, // group data
    input wire IO_SET_IN, // bit set
    input wire IO_CLR_IN, // bit clear
    input wire [31:0] AD_IN, // sensed lines
    input wire [31:0] AD_OUT, // driven lines
    input wire [31:0] AD_OE_OUT, // line enables
    input wire RAS_N_OUT, // row strobe
    input wire CAS_N_OUT, // column strobe
    input wire DOB_N_OUT, // data on bus
    input wire OE_N_OUT, // output enable
    input wire [7:0] BIT_OUT, // bit outputs
    input wire [7:0] BITS_SAMPLED_OUT, // sampled bits
    input wire RDATA_VALID_OUT, // cycle done
    input wire TRAP_OUT // fault trap
);
    default clocking cb @(posedge REF_CLK_IN);
    endclocking
    default disable iff (!RESET_N_IN);
    // qualifying state for shared-line samples
    wire samp = !RAS_N_OUT && CAS_N_OUT;
    a_ras_rise_idle: assert property ($rose(RAS_N_OUT) |-> CAS_N_OUT && DOB_N_OUT)
        else $error("row released inside column cycle");
    a_cas_in_row: assert property ($fell(CAS_N_OUT) |-> !RAS_N_OUT && AD_OE_OUT == 32'hffff_ffff)
        else $error("column strobe without row or address");
    a_col_data_seq: assert property ($fell(CAS_N_OUT) |=> !DOB_N_OUT && !CAS_N_OUT ##1 !DOB_N_OUT ##1 DOB_N_OUT && CAS_N_OUT)
        else $error("column and data phase order wrong");
    a_oe_read_data: assert property (!OE_N_OUT |-> !DOB_N_OUT && AD_OE_OUT == 32'h0)
        else $error("output enable outside read data");
    // lag of one cycle allowed between the bit register and the lines
    a_bits_on_lines: assert property (RAS_N_OUT && $past(RAS_N_OUT) && $past(RESET_N_IN) && $stable(BIT_OUT) |-> AD_OUT[7:0] == BIT_OUT && AD_OE_OUT[7:0] == 8'hff)
        else $error("bit outputs not on low lines");
    a_main_write: assert property (MAIN_WR_IN && !IO_SET_IN && !IO_CLR_IN |=> BIT_OUT == $past(MAIN_WDATA_IN))
        else $error("group write lost");
    a_low_undriven: assert property (samp |-> AD_OE_OUT[8:0] == 9'h0)
        else $error("low lines driven while sampled");
    a_ad_bits: assert property ($past(samp) && !$past(BIT_PIN_SEL_IN) && $past(RESET_N_IN) |-> BITS_SAMPLED_OUT == $past(AD_IN[7:0]))
        else $error("shared-line bits not sampled");
    a_bits_hold: assert property (!$past(samp) && !$past(BIT_PIN_SEL_IN) && $past(RESET_N_IN) |-> $stable(BITS_SAMPLED_OUT))
        else $error("sampled bits changed outside window");
    a_trap_abort: assert property (TRAP_OUT |-> RDATA_VALID_OUT && CAS_N_OUT && DOB_N_OUT)
        else $error("trap without abort");
    c_trap: cover property (TRAP_OUT);
    c_read: cover property (!OE_N_OUT);
    c_samp: cover property (samp && !BIT_PIN_SEL_IN);
endmodule
bind mem_bus_pins mem_pins_sva u_mem_pins_sva (
    .REF_CLK_IN(REF_CLK_IN), .RESET_N_IN(RESET_N_IN),
    .BIT_PIN_SEL_IN(BIT_PIN_SEL_IN), .MAIN_WR_IN(MAIN_WR_IN),
    .MAIN_WDATA_IN(MAIN_WDATA_IN), .IO_SET_IN(IO_SET_IN),
    .IO_CLR_IN(IO_CLR_IN), .AD_IN(AD_IN), .AD_OUT(AD_OUT),
    .AD_OE_OUT(AD_OE_OUT), .RAS_N_OUT(RAS_N_OUT), .CAS_N_OUT(CAS_N_OUT),
    .DOB_N_OUT(DOB_N_OUT), .OE_N_OUT(OE_N_OUT), .BIT_OUT(BIT_OUT),
    .BITS_SAMPLED_OUT(BITS_SAMPLED_OUT),
    .RDATA_VALID_OUT(RDATA_VALID_OUT), .TRAP_OUT(TRAP_OUT));
`default_nettype wire

// [sim/mem_model.sv]
// far side of the bus: memory answering reads, and an outside source
// driving bit inputs and line 8; assumes registered bus outputs
`timescale 1ns/10ps
`default_nettype none
module mem_model #(
    parameter logic [31:0] RD_WORD = 32'h1234_abcd
) (
    input wire logic clk_in, // clock
    input wire logic [31:0] ad_out_in, // block drive
    input wire logic [31:0] ad_oe_in, // block enable
    input wire logic ras_n_in, // row strobe
    input wire logic cas_n_in, // column strobe
    input wire logic oe_n_in, // output enable
    input wire logic [7:0] bits_in, // bits to offer
    input wire logic ad8_in, // line 8 level
    output logic [31:0] ad_sense_out // resolved lines
);
    logic [31:0] junk_reg = 32'h0f3c_5a96;
    logic [31:0] ext;
    // undriven lines flip each cycle so a stale value never passes
    always @(posedge clk_in) begin
        junk_reg <= ~junk_reg;
    end
    // window drive
    // line 8 level is set before the row strobe falls
    always @* begin
        if (!ras_n_in && cas_n_in) begin
            ext = {junk_reg[31:9], ad8_in, bits_in};
        end else if (!oe_n_in) begin
            ext = RD_WORD;
        end else begin
            ext = junk_reg;
        end
    end
    // each line follows whoever enables it
    assign ad_sense_out = (ad_oe_in & ad_out_in) | (~ad_oe_in & ext);
endmodule
`default_nettype wire

// [sim/testbench.sv]
// bench for mem_bus_pins with the memory model on the shared lines
// assumes the checker is bound in by its own file
`timescale 1ns/10ps
`default_nettype none
module testbench;
    localparam logic [31:0] RD = 32'h1234_abcd;
    logic clk, rst_n, pwrup, fsel, bsel, req, rd, mn, nr, fault_n;
    logic mwr, ioset, ioclr, mad8, trapped;
    logic [2:0] iosel;
    logic [7:0] bit_in, mwd, mbits;
    logic [22:0] col;
    wire [31:0] ad_in, ad_out, ad_oe, rdata;
    wire ras_n, cas_n, dob_n, oe_n, rvalid, trap, cpu_rst;
    wire [7:0] bit_out, bits_s;
    int bad_count, n_checks, lat;
    mem_bus_pins u_mem_bus_pins (.REF_CLK_IN(clk), .RESET_N_IN(rst_n),
        .PWRUP_IN(pwrup), .FAULT_PIN_SEL_IN(fsel), .BIT_PIN_SEL_IN(bsel),
        .REQ_IN(req), .REQ_READ_IN(rd), .REQ_MAIN_IN(mn), .NEW_ROW_IN(nr),
        .ROW_ADDR_IN(~col), .COL_ADDR_IN(col), .WDATA_IN({9'h0, col}),
        .FAULT_N_IN(fault_n), .BIT_IN(bit_in), .MAIN_WR_IN(mwr),
        .MAIN_WDATA_IN(mwd), .IO_SET_IN(ioset), .IO_CLR_IN(ioclr),
        .IO_SEL_IN(iosel), .AD_IN(ad_in), .AD_OUT(ad_out),
        .AD_OE_OUT(ad_oe), .RAS_N_OUT(ras_n), .CAS_N_OUT(cas_n),
        .DOB_N_OUT(dob_n), .OE_N_OUT(oe_n), .BIT_OUT(bit_out),
        .BITS_SAMPLED_OUT(bits_s), .RDATA_VALID_OUT(rvalid),
        .RDATA_OUT(rdata), .TRAP_OUT(trap), .CPU_RESET_OUT(cpu_rst));
    mem_model #(.RD_WORD(RD)) u_mem_model (.clk_in(clk),
        .ad_out_in(ad_out), .ad_oe_in(ad_oe), .ras_n_in(ras_n),
        .cas_n_in(cas_n), .oe_n_in(oe_n), .bits_in(mbits),
        .ad8_in(mad8), .ad_sense_out(ad_in));
    // free-running clock, 40 ns
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    task automatic chk(input string what, input logic [31:0] e,
        input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            $display("mismatch %s expected %h seen %h", what, e, g);
            bad_count++;
        end
    endtask
    // one bus cycle; lat counts edges up to the done pulse, take edge is 1
    task automatic cyc(input logic r, input logic m, input logic n);
        @(posedge clk);
        req <= 1'b1;
        rd <= r;
        mn <= m;
        nr <= n;
        col <= col + 23'h11;
        lat = 0;
        do begin
            @(posedge clk);
            req <= 1'b0;
            #1;
            lat++;
        end while (rvalid !== 1'b1 && lat < 20);
        trapped = trap;
    endtask
    task automatic s_closed_write;
        cyc(1'b0, 1'b1, 1'b0);
        chk("closed latency", 32'd6, lat);
        chk("row held", 32'h0, ras_n);
        chk("column off", 32'h1, cas_n);
        chk("pin bits", 32'h3c, bits_s);
        chk("pin reset", 32'h0, cpu_rst);
    endtask
    task automatic s_open_read;
        cyc(1'b1, 1'b1, 1'b0);
        chk("open latency", 32'd4, lat);
        chk("read data", RD, rdata);
        chk("oe after read", 32'h1, oe_n);
    endtask
    task automatic s_faults;
        @(posedge clk);
        fault_n <= 1'b0;
        cyc(1'b0, 1'b1, 1'b0);
        chk("pin abort latency", 32'd1, lat);
        chk("pin trap", 32'h1, trapped);
        chk("row kept open", 32'h0, ras_n);
        @(posedge clk);
        fault_n <= 1'b1;
        fsel <= 1'b0;
        mad8 <= 1'b0;
        // a new row is needed so that the row strobe falls and line 8 is read
        cyc(1'b0, 1'b1, 1'b1);
        chk("line abort latency", 32'd5, lat);
        chk("line trap", 32'h1, trapped);
        chk("row closed", 32'h1, ras_n);
        chk("line 8 ignored", 32'h0, cpu_rst);
    endtask
    task automatic s_bit_out;
        @(posedge clk);
        fsel <= 1'b1;
        mad8 <= 1'b1;
        mwr <= 1'b1;
        mwd <= 8'ha5;
        @(posedge clk);
        mwr <= 1'b0;
        ioset <= 1'b1;
        iosel <= 3'h6;
        @(posedge clk);
        ioset <= 1'b0;
        ioclr <= 1'b1;
        iosel <= 3'h0;
        @(posedge clk);
        ioset <= 1'b1;
        iosel <= 3'h3;
        #1;
        chk("bit outputs", 32'he4, bit_out);
        @(posedge clk);
        ioset <= 1'b0;
        ioclr <= 1'b0;
        #1;
        chk("set wins", 32'hec, bit_out);
        repeat (2) @(posedge clk);
        #1;
        chk("bits on lines", 32'hec, ad_out[7:0]);
        chk("bits driven", 32'hff, ad_oe[7:0]);
    endtask
    task automatic s_ad_mode;
        @(posedge clk);
        pwrup <= 1'b1;
        bsel <= 1'b0;
        mbits <= 8'hc6;
        mad8 <= 1'b0;
        @(posedge clk);
        pwrup <= 1'b0;
        cyc(1'b0, 1'b1, 1'b0);
        chk("line bits", 32'hc6, bits_s);
        chk("line reset", 32'h1, cpu_rst);
        @(posedge clk);
        mbits <= 8'h11;
        mad8 <= 1'b1;
        bit_in <= 8'h77;
        cyc(1'b1, 1'b0, 1'b1);
        chk("new row latency", 32'd8, lat);
        chk("line bits again", 32'h11, bits_s);
        chk("reset released", 32'h0, cpu_rst);
    endtask
    task automatic end_of_test;
        if (bad_count == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // pin-mode strap: reset low while power-up window is open
    initial begin
        {rst_n, req, rd, mn, nr, mwr, ioset, ioclr} = 8'h0;
        {pwrup, fsel, bsel, fault_n, mad8} = 5'h1f;
        {iosel, mwd, col} = 34'h0;
        bit_in = 8'h3c;
        mbits = 8'h5a;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        pwrup <= 1'b0;
        s_closed_write();
        s_open_read();
        s_faults();
        s_bit_out();
        s_ad_mode();
        end_of_test();
    end
    // the whole run needs well under 200 cycles
    initial begin
        repeat (3000) @(posedge clk);
        bad_count++;
        end_of_test();
    end
endmodule
`default_nettype wire
